// file: inc/dolc_map.svh
`ifndef DOLC_MAP_SVH
`define DOLC_MAP_SVH

// Register byte offsets
`define DOLC_ADR_CTRL 8'h00
`define DOLC_ADR_LAT 8'h04
`define DOLC_ADR_STAT 8'h08

// Control register bits
`define DOLC_CTRL_W 6
`define DOLC_CTRL_DLL 0
`define DOLC_CTRL_DYN9 1
`define DOLC_CTRL_DYN10 2
`define DOLC_CTRL_BUFOFF 3
`define DOLC_CTRL_PRE2 4
`define DOLC_CTRL_CRC 5
`define DOLC_CTRL_RST 6'h01

// Latency register fields
`define DOLC_CAS_MSB 5
`define DOLC_CAS_LSB 0
`define DOLC_ADD_MSB 13
`define DOLC_ADD_LSB 8
`define DOLC_PAR_MSB 19
`define DOLC_PAR_LSB 16
`define DOLC_CAS_RST 6'h09
`define DOLC_ADD_RST 6'h00
`define DOLC_PAR_RST 4'h0

// Status register fields
`define DOLC_STAT_TERM_LSB 0
`define DOLC_STAT_WIN 2
`define DOLC_STAT_ASYNC 3
`define DOLC_STAT_PD 4
`define DOLC_STAT_LAT_LSB 8

// Write termination latencies
`define DOLC_ON_SUB1 7'h02
`define DOLC_ON_SUB2 7'h03
`define DOLC_OFF4_1N 4'h4
`define DOLC_OFF8_1N 4'h6
`define DOLC_OFF_1C 4'h7
`define DOLC_OFF4_2N 4'h5
`define DOLC_OFF8_2N 4'h7
`define DOLC_OFF_2C 4'h8

// Delay line geometry
`define DOLC_DEPTH 64
`define DOLC_TAP_W 6
`define DOLC_TAP_MAX 6'h3F
`define DOLC_TAP_MIN 6'h00

`endif

// file: inc/dolc_pkg.sv
`include "dolc_map.svh"

package dolc_pkg;

	// Termination strength chosen by the block
	typedef enum logic [1:0] {DOLC_PARK, DOLC_NOM, DOLC_WR} dolc_term_e;

	// Main block state
	typedef struct packed {
		logic [`DOLC_CTRL_W-1:0] ctrl;
		logic [5:0] cas_lat;
		logic [5:0] add_lat;
		logic [3:0] par_lat;
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic cke1;
		logic cke2;
		logic [3:0] remain;
		logic win;
		dolc_term_e term;
		logic pd;
		logic ack;
		logic [31:0] dat;
	} dolc_state_s;

	// Delay line state
	typedef struct packed {
		logic [`DOLC_DEPTH-1:0][2:0] sr;
	} dolc_dly_s;

endpackage

// file: verilog/dolc_delay_line.sv
`timescale 1ns/100ps
`include "dolc_map.svh"

module dolc_delay_line
	import dolc_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Data in and tap select
	input wire logic [2:0] d_i,
	input wire logic [`DOLC_TAP_W-1:0] tap_i,
	// Delayed data
	output logic [2:0] q_o
);

	dolc_dly_s s_q;
	dolc_dly_s s_d;

	// Shift one stage per cycle; stage 0 is one cycle late
	always_comb
	begin
		s_d = s_q;
		s_d.sr = {s_q.sr[`DOLC_DEPTH-2:0], d_i};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Tap i gives a delay of i+1 cycles
	assign q_o = s_q.sr[tap_i];

endmodule

// file: verilog/dolc_term_ctrl.sv
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps

// Function
// - 1tCK preamble, CRC off: write termination starts write_latency-2 cycles after write.
// - 1tCK, CRC off: write termination ends 4 (chop) or 6 cycles later.
// - On latency WL-2 or WL-3; off offsets 7/7, 5/7, 8/8 per mode.
// - Delay-locked loop off (mode one bit A0 clear) selects asynchronous mode.
// - Asynchronous mode applies the pin with no additive or clock latency.
// - Async pin high: reach nominal within the turn-on window.
// - Async pin low: reach park within the turn-off window.
// - Buffer deactivation (mode five A5) means no nominal during power-down.
// - Samples near power-down entry may give nominal or park.
// - Dynamic termination enabled when mode two bit A9 or A10 set.
// - Outside write windows: park when pin low, nominal when high.
// - Write latency is cas plus additive plus parity latency.
// - No dynamic write termination while the delay-locked loop is off.
`include "dolc_map.svh"

module dolc_term_ctrl
	import dolc_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Device pins
	input wire logic termination_control_pin_i,
	input wire logic cke_i,
	input wire logic wr_cmd_i,
	input wire logic wr_chop4_i,
	// Termination select
	output logic [1:0] term_sel_o,
	output logic win_active_o
);

	dolc_state_s s_q;
	dolc_state_s s_d;
	logic [2:0] dly_q;
	logic [`DOLC_TAP_W-1:0] tap;
	logic [6:0] wr_lat;
	logic [6:0] on_lat;
	logic dll_on;
	logic dyn_ok;
	logic pin_eff;
	logic req;

	// Switch-off offset after the on point, per preamble, CRC and burst
	function automatic logic [3:0] off_ofs(input logic pre2, input logic crc, input logic chop);
		logic [3:0] r;
		r = `DOLC_OFF8_1N;
		if (!pre2 && !crc)
			r = chop ? `DOLC_OFF4_1N : `DOLC_OFF8_1N;
		else if (!pre2 && crc)
			r = `DOLC_OFF_1C;
		else if (pre2 && !crc)
			r = chop ? `DOLC_OFF4_2N : `DOLC_OFF8_2N;
		else
			r = `DOLC_OFF_2C;
		return r;
	endfunction

	// Latencies derived from the programmed fields
	always_comb
	begin
		wr_lat = {1'b0, s_q.cas_lat} + {1'b0, s_q.add_lat} + {3'b000, s_q.par_lat};
		on_lat = wr_lat - (s_q.ctrl[`DOLC_CTRL_PRE2] ? `DOLC_ON_SUB2 : `DOLC_ON_SUB1);
		// Clamp small or wrapped latencies to the shortest tap
		if (on_lat == 7'h00 || on_lat[6])
			tap = `DOLC_TAP_MIN;
		else
			tap = on_lat[`DOLC_TAP_W-1:0] - 6'h01;
		dll_on = s_q.ctrl[`DOLC_CTRL_DLL];
		dyn_ok = dll_on && (s_q.ctrl[`DOLC_CTRL_DYN9] || s_q.ctrl[`DOLC_CTRL_DYN10]);
		// Async mode uses the synchronised pin directly
		pin_eff = dll_on ? dly_q[0] : s_q.sync2[0];
		req = wb_cyc_i && wb_stb_i && !s_q.ack;
	end

	// Pin, write and chop share one delay line so they stay aligned
	dolc_delay_line u_dly
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(s_q.sync2),
		.tap_i(tap),
		.q_o(dly_q)
	);

	// Next state: synchronisers, window, termination, bus
	always_comb
	begin
		s_d = s_q;
		s_d.sync1 = {wr_chop4_i, wr_cmd_i, termination_control_pin_i};
		s_d.sync2 = s_q.sync1;
		s_d.cke1 = cke_i;
		s_d.cke2 = s_q.cke1;
		// Power-down only matters with the input buffer deactivated
		s_d.pd = s_q.ctrl[`DOLC_CTRL_BUFOFF] && !s_q.cke2;
		// Each delayed write reloads the count; later writes extend it
		if (!dyn_ok)
			s_d.remain = 4'h0;
		else if (dly_q[1])
			s_d.remain = off_ofs(s_q.ctrl[`DOLC_CTRL_PRE2], s_q.ctrl[`DOLC_CTRL_CRC], dly_q[2]);
		else if (s_q.remain != 4'h0)
			s_d.remain = s_q.remain - 4'h1;
		// Window flag registered so the output comes from a flop
		s_d.win = (s_d.remain != 4'h0);
		// Park chosen at once on entry; ambiguity allows either
		if (s_d.remain != 4'h0)
			s_d.term = DOLC_WR;
		else if (pin_eff && !s_d.pd)
			s_d.term = DOLC_NOM;
		else
			s_d.term = DOLC_PARK;
		// Bus answers every access one cycle after the request
		s_d.ack = req;
		s_d.dat = 32'h0000_0000;
		if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == `DOLC_ADR_CTRL)
			s_d.ctrl = wb_dat_i[`DOLC_CTRL_W-1:0];
		if (req && wb_we_i && wb_adr_i == `DOLC_ADR_LAT)
		begin
			if (wb_sel_i[0])
				s_d.cas_lat = wb_dat_i[`DOLC_CAS_MSB:`DOLC_CAS_LSB];
			if (wb_sel_i[1])
				s_d.add_lat = wb_dat_i[`DOLC_ADD_MSB:`DOLC_ADD_LSB];
			if (wb_sel_i[2])
				s_d.par_lat = wb_dat_i[`DOLC_PAR_MSB:`DOLC_PAR_LSB];
		end
		if (req && !wb_we_i)
		begin
			case (wb_adr_i)
				`DOLC_ADR_CTRL:
					s_d.dat[`DOLC_CTRL_W-1:0] = s_q.ctrl;
				`DOLC_ADR_LAT:
				begin
					s_d.dat[`DOLC_CAS_MSB:`DOLC_CAS_LSB] = s_q.cas_lat;
					s_d.dat[`DOLC_ADD_MSB:`DOLC_ADD_LSB] = s_q.add_lat;
					s_d.dat[`DOLC_PAR_MSB:`DOLC_PAR_LSB] = s_q.par_lat;
				end
				`DOLC_ADR_STAT:
				begin
					s_d.dat[`DOLC_STAT_TERM_LSB+1:`DOLC_STAT_TERM_LSB] = s_q.term;
					s_d.dat[`DOLC_STAT_WIN] = (s_q.remain != 4'h0);
					s_d.dat[`DOLC_STAT_ASYNC] = !dll_on;
					s_d.dat[`DOLC_STAT_PD] = s_q.pd;
					s_d.dat[`DOLC_STAT_LAT_LSB+6:`DOLC_STAT_LAT_LSB] = wr_lat;
				end
				default:
					s_d.dat = 32'h0000_0000;
			endcase
		end
	end

	// State register with synchronous reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_q <= '0;
			s_q.ctrl <= `DOLC_CTRL_RST;
			s_q.cas_lat <= `DOLC_CAS_RST;
			s_q.add_lat <= `DOLC_ADD_RST;
			s_q.par_lat <= `DOLC_PAR_RST;
			s_q.term <= DOLC_PARK;
		end
		else
			s_q <= s_d;
	end

	// Outputs straight from the state register
	assign wb_dat_o = s_q.dat;
	assign wb_ack_o = s_q.ack;
	assign term_sel_o = s_q.term;
	assign win_active_o = s_q.win;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Window onset and a shortest chop window
	sequence win_start_s;
		dyn_ok && dly_q[1];
	endsequence
	sequence win_hold4_s;
		(term_sel_o == DOLC_WR)[*4];
	endsequence

	chk_win_turn_on: assert property (win_start_s |=> win_hold4_s)
		else $error("write termination not held after its on point");
	chk_win_turn_off: assert property ((s_q.remain == 4'h1) && !dly_q[1] && dyn_ok |=> term_sel_o != DOLC_WR)
		else $error("write termination outlived its window");
	chk_off_offset: assert property (win_start_s |=> s_q.remain == off_ofs(
		$past(s_q.ctrl[`DOLC_CTRL_PRE2]), $past(s_q.ctrl[`DOLC_CTRL_CRC]), $past(dly_q[2])))
		else $error("switch-off offset wrong for mode");
	chk_async_on: assert property (!dll_on && s_q.sync2[0] && !s_d.pd |=> term_sel_o == DOLC_NOM)
		else $error("async pin high did not give nominal");
	chk_async_off: assert property (!dll_on && !s_q.sync2[0] |=> term_sel_o == DOLC_PARK)
		else $error("async pin low did not give park");
	chk_pd_no_nom: assert property (s_q.pd |-> term_sel_o != DOLC_NOM)
		else $error("nominal given in power-down");
	chk_dyn_gate: assert property (!dyn_ok |=> !win_active_o)
		else $error("write window without dynamic enable");
	chk_dll_off_dyn: assert property (!dll_on ##1 !dll_on |-> term_sel_o != DOLC_WR)
		else $error("write termination with loop off");
	chk_sync_nom: assert property (dll_on && dly_q[0] && s_d.remain == 4'h0 && !s_d.pd |=> term_sel_o == DOLC_NOM)
		else $error("delayed pin high did not give nominal");
	chk_lat_sum: assert property (wb_ack_o && $past(wb_adr_i) == `DOLC_ADR_STAT && !$past(wb_we_i) |->
		wb_dat_o[`DOLC_STAT_LAT_LSB+6:`DOLC_STAT_LAT_LSB] == $past(wr_lat))
		else $error("status write latency wrong");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

endmodule

// file: bench/dolc_host_model.sv
`timescale 1ns/100ps

module dolc_host_model #(
	parameter int ENTRY_DLY = 4,
	parameter int EXIT_DLY = 4
) (
	// Clock
	input wire logic clk_i,
	// Pins toward the device
	output logic termination_control_pin_o = 1'b0,
	output logic cke_o = 1'b1,
	output logic wr_cmd_o = 1'b0,
	output logic wr_chop4_o = 1'b0
);
	logic float_q = 1'b0;

	// One-cycle write pulse; a released pin toggles so no stale level looks valid
	always @(posedge clk_i)
	begin
		if (wr_cmd_o)
			wr_cmd_o <= 1'b0;
		if (float_q)
			termination_control_pin_o <= ~termination_control_pin_o;
	end

	// Write command with its burst kind
	task automatic wr(input logic chop);
		@(posedge clk_i);
		wr_cmd_o <= 1'b1;
		wr_chop4_o <= chop;
	endtask

	// Drive the termination pin to a steady level
	task automatic pin(input logic v);
		@(posedge clk_i);
		termination_control_pin_o <= v;
	endtask

	// Entry: pin left untouched until the entry delay has run out
	task automatic pd_enter;
		@(posedge clk_i);
		cke_o <= 1'b0;
		repeat (ENTRY_DLY) @(posedge clk_i);
		float_q <= 1'b1;
	endtask

	// Exit: stop toggling first, so the low drive never races the toggle
	task automatic pd_exit;
		@(posedge clk_i);
		float_q <= 1'b0;
		@(posedge clk_i);
		termination_control_pin_o <= 1'b0;
		cke_o <= 1'b1;
		repeat (EXIT_DLY) @(posedge clk_i);
	endtask
endmodule

// file: bench/dolc_term_ctrl_test.sv
`timescale 1ns/100ps
`include "dolc_map.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch %s exp %0h got %0h", n, e, g); end end

module dolc_term_ctrl_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, rd;
	logic wb_ack_o, pin, cke, wrc, chop, win_active_o;
	logic [1:0] term_sel_o;
	int error_cnt = 0;
	int checked = 0;
	int offt[8] = '{6, 7, 7, 8, 4, 5, 7, 8};

	dolc_term_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .termination_control_pin_i(pin), .cke_i(cke),
		.wr_cmd_i(wrc), .wr_chop4_i(chop), .term_sel_o(term_sel_o), .win_active_o(win_active_o));
	dolc_host_model pm (.clk_i(clk_i), .termination_control_pin_o(pin), .cke_o(cke),
		.wr_cmd_o(wrc), .wr_chop4_o(chop));

	// 40 MHz clock
	initial
	begin
		forever #12.5 clk_i = ~clk_i;
	end

	// Verdict and end of run
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Classic single Wishbone cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 20);
		// A missing ack ends the run; otherwise take data and release
		if (n >= 20)
		begin
			error_cnt++;
			tally_and_finish();
		end
		else
		begin
			r = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			wb_we_i <= 1'b0;
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		`CHK("register", e, r)
	endtask

	// Per-cycle check of a write window; lead shifts the start for an earlier overlapping write
	task automatic chk_win(input logic c, input int on, input int off, input logic [1:0] base, input int lead);
		logic [1:0] e;
		pm.wr(c);
		for (int k = 1; k < on + off + 4; k++)
		begin
			@(posedge clk_i);
			#1;
			// Two synchroniser flops plus one register stage ahead of the on latency
			e = (k >= on + 3 - lead && k < on + 3 + off) ? 2'h2 : base;
			`CHK("term_sel", e, term_sel_o)
			`CHK("win_active", e == 2'h2, win_active_o)
		end
	endtask

	// Asynchronous pin change: visible on the third edge, not before
	task automatic chk_pin(input logic v);
		pm.pin(v);
		for (int k = 1; k < 4; k++)
		begin
			@(posedge clk_i);
			#1;
			`CHK("async term", (k >= 3) ? {1'b0, v} : {1'b0, ~v}, term_sel_o)
		end
	endtask

	task automatic nom_chk(input logic [1:0] e);
		repeat (14) @(posedge clk_i);
		#1;
		`CHK("term_sel", e, term_sel_o)
	endtask

	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rchk(`DOLC_ADR_CTRL, 32'h1);
		rchk(`DOLC_ADR_LAT, 32'h9);
		wb(1'b1, 8'h0C, 32'hFFFFFFFF, rd);
		rchk(8'h0C, 32'h0);
		wb(1'b1, `DOLC_ADR_LAT, 32'h00010209, rd);
		rchk(`DOLC_ADR_STAT, 32'h00000C00);
		// Every preamble, CRC and burst kind, dynamic enable by either bit
		for (int m = 0; m < 8; m++)
		begin
			wb(1'b1, `DOLC_ADR_CTRL, 32'({m[1], m[0], 1'b0, m[2], ~m[2], 1'b1}), rd);
			chk_win(m[2], 10 - m[0], offt[m], 2'h0, 0);
		end
		wb(1'b1, `DOLC_ADR_CTRL, 32'h3, rd);
		pm.wr(1'b1);
		repeat (2) @(posedge clk_i);
		chk_win(1'b0, 10, 6, 2'h0, 3);
		pm.pin(1'b1);
		nom_chk(2'h1);
		chk_win(1'b0, 10, 6, 2'h1, 0);
		wb(1'b1, `DOLC_ADR_CTRL, 32'h1, rd);
		chk_win(1'b0, 10, 0, 2'h1, 0);
		pm.pin(1'b0);
		wb(1'b1, `DOLC_ADR_CTRL, 32'h2, rd);
		nom_chk(2'h0);
		rchk(`DOLC_ADR_STAT, 32'h00000C08);
		chk_pin(1'b1);
		chk_win(1'b0, 10, 0, 2'h1, 0);
		chk_pin(1'b0);
		wb(1'b1, `DOLC_ADR_CTRL, 32'h9, rd);
		pm.pin(1'b1);
		nom_chk(2'h1);
		pm.pd_enter();
		#1;
		`CHK("pd term", 2'h0, term_sel_o)
		rchk(`DOLC_ADR_STAT, 32'h00000C10);
		pm.pd_exit();
		pm.pin(1'b1);
		nom_chk(2'h1);
		// Mid-run reset: pin still high, yet park until the delay line refills
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		`CHK("reset term", 2'h0, term_sel_o)
		`CHK("reset win", 1'b0, win_active_o)
		rchk(`DOLC_ADR_CTRL, 32'h1);
		rchk(`DOLC_ADR_LAT, 32'h9);
		tally_and_finish();
	end
endmodule
